// ===== verilog/aicl_pkg.sv
// Package with cause bit maps, command codes and carrier types for the interrupt cause logic.
package aicl_pkg;

  // ==========================================================================
  // Widths
  localparam int ERR_W = 18;
  localparam int ENA_W = 19;
  localparam int EVT_W = 20;
  localparam int BUF_W = 32;
  localparam int CMD_W = 8;

  // ==========================================================================
  // Commands
  localparam logic [CMD_W-1:0] CMD_RD_ERR = 8'hF2;
  localparam logic [CMD_W-1:0] CMD_RD_EVT = 8'hF3;
  localparam logic [CMD_W-1:0] CMD_WR_ENA = 8'hAC;
  localparam logic [CMD_W-1:0] CMD_RD_ENA = 8'hAD;

  // ==========================================================================
  // Error cause bit positions
  localparam int ERR_CMP1 = 0;
  localparam int ERR_CMP2 = 1;
  localparam int ERR_CMP3 = 2;
  localparam int ERR_CMP4 = 3;
  localparam int ERR_CMP5 = 4;
  localparam int ERR_PEL = 5;
  localparam int ERR_NEL = 6;
  localparam int ERR_ALM = 7;
  localparam int ERR_SSTP = 8;
  localparam int ERR_EMG = 9;
  localparam int ERR_SD = 10;
  localparam int ERR_UNDEF = 11;
  localparam int ERR_DATA = 12;
  localparam int ERR_IPART = 13;
  localparam int ERR_POVF = 14;
  localparam int ERR_IOVR = 15;
  localparam int ERR_ENC = 16;
  localparam int ERR_PUL = 17;

  // ==========================================================================
  // Event cause bit positions
  localparam int EV_ASTOP = 0;
  localparam int EV_NEXT = 1;
  localparam int EV_PREG = 2;
  localparam int EV_C5PREG = 3;
  localparam int EV_ACC_S = 4;
  localparam int EV_ACC_E = 5;
  localparam int EV_DEC_S = 6;
  localparam int EV_DEC_E = 7;
  localparam int EV_CMP1 = 8;
  localparam int EV_CLR = 13;
  localparam int EV_LTC = 14;
  localparam int EV_ORG = 15;
  localparam int EV_SD = 16;
  localparam int EV_PDR = 17;
  localparam int EV_NDR = 18;
  localparam int EV_STA = 19;
  localparam int EN_DR = 17;
  localparam int EN_STA = 18;
  localparam int NUM_CMP = 5;

  // ==========================================================================
  // Reset values
  localparam logic [ERR_W-1:0] ERR_RST = 18'h00000;
  localparam logic [ENA_W-1:0] ENA_RST = 19'h00000;
  localparam logic [EVT_W-1:0] EVT_RST = 20'h00000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [NUM_CMP-1:0] cmp_stop;
    logic pos_end_limit_in;
    logic neg_end_limit_in;
    logic alarm_in;
    logic sync_stop;
    logic emergency_stop;
    logic slowdown_stop;
    logic op_data;
    logic interp_partner;
    logic pulser_overflow;
    logic interp_overrange;
    logic encoder_input;
    logic pulser_input;
  } aicl_err_t;

  typedef struct packed {
    logic auto_stop;
    logic next_start;
    logic preg_writable;
    logic cmp5_preg_writable;
    logic accel_start;
    logic accel_end;
    logic decel_start;
    logic decel_end;
    logic [NUM_CMP-1:0] cmp_match;
    logic counter_cleared;
    logic counter_latched;
    logic origin_latched;
    logic slowdown_on;
  } aicl_evt_t;

  typedef struct packed {
    logic valid;
    logic [CMD_W-1:0] code;
    logic [BUF_W-1:0] wdata;
  } aicl_cmd_t;

endpackage

// ===== verilog/aicl_edge.sv
// Rising and any-edge detector for level inputs sampled on the system clock.
`timescale 1ns/100ps
`default_nettype none
module aicl_edge #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Levels
  input wire logic [W-1:0] level_i,
  // Edges
  output logic [W-1:0] rise_o,
  output logic [W-1:0] change_o
);

  // ==========================================================================
  // Previous level
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign change_o = level_i ^ prev_reg;

endmodule
`default_nettype wire

// ===== verilog/aicl_top.sv
// Per-axis interrupt cause logic with command-driven cause reads.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Bits 0,1 set on comparator 1,2 stops.
// R2: Bits 2,3,4 set on comparator 3,4,5 stops.
// R3: Bits 5,6,7 set on end-limit and alarm stops.
// R4: Bits 8,9 set on sync and emergency stops.
// R5: Bit 10 on slow-down stop; bit 11 zero.
// R6: Bit 12 set on operation data error.
// R7: Bit 13 set on interpolation partner stop.
// R8: Bit 14 set on pulser counter overflow.
// R9: Bit 15 set on interpolation over-range stop.
// R10: Bits 16,17 on encoder, pulser input errors.
// R11: Event sets cause; enable gates its interrupt.
// R12: Events 0,1 auto stop and next start.
// R13: Events 2,3 flag pre-registers writable.
// R14: Events 4-12 accel, decel, comparator matches.
// R15: Events 13-15 clear, latch, origin latch.
// R16: Event 16 slow-down input turned on.
// R17: Causes 17,18 direction changes; enable 17 gates.
// R18: Cause 19 external start; enable 18 gates.
// R19: Every error cause drives interrupt with no enable bit.
// R20: Interrupt held until all error and enabled event causes cleared.
// R21: Error and event read commands copy cause to buffer, clear.
// R22: Mask keeps output high, status still updates.
// R23: Causes accumulate; same-cycle set beats clear.
module aicl_top
  import aicl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Error stop sources
  input wire aicl_err_t err_i,
  // Event sources
  input wire aicl_evt_t evt_i,
  // Input levels watched for events
  input wire logic slow_down_in_i,
  input wire logic pos_direction_in_i,
  input wire logic neg_direction_in_i,
  input wire logic ext_start_in_i,
  // Mask setting
  input wire logic int_mask_i,
  // Command port
  input wire aicl_cmd_t cmd_i,
  // Buffer and status
  output logic [BUF_W-1:0] buf_o,
  output logic buf_valid_o,
  output logic err_pending_o,
  output logic evt_pending_o,
  // Interrupt to host
  output logic int_n_o
);

  // ==========================================================================
  // Cause and enable registers
  logic [ERR_W-1:0] error_stop_cause_reg;
  logic [ERR_W-1:0] error_stop_cause_next;
  logic [ENA_W-1:0] event_irq_enable_reg;
  logic [EVT_W-1:0] event_cause_reg;
  logic [EVT_W-1:0] event_cause_next;
  logic [ERR_W-1:0] err_set;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_gate;
  logic [3:0] rise;
  logic [3:0] change;
  logic rd_err;
  logic rd_evt;
  logic wr_ena;
  logic rd_ena;
  logic irq_req;

  // Widens an enable word to cause positions; bit 17 covers both direction causes.
  function automatic logic [EVT_W-1:0] ena_to_cause(input logic [ENA_W-1:0] en);
    logic [EVT_W-1:0] g;
    g = '0;
    g[EN_DR:0] = en[EN_DR:0];
    g[EV_NDR] = en[EN_DR]; // [R17]
    g[EV_STA] = en[EN_STA]; // [R18]
    return g;
  endfunction

  // ==========================================================================
  // Input edge detection
  aicl_edge #(
    .W(4)
  ) u_edge (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .level_i({ext_start_in_i, neg_direction_in_i, pos_direction_in_i, slow_down_in_i}),
    .rise_o(rise),
    .change_o(change)
  );

  // ==========================================================================
  // Command decode
  assign rd_err = cmd_i.valid && (cmd_i.code == CMD_RD_ERR);
  assign rd_evt = cmd_i.valid && (cmd_i.code == CMD_RD_EVT);
  assign wr_ena = cmd_i.valid && (cmd_i.code == CMD_WR_ENA);
  assign rd_ena = cmd_i.valid && (cmd_i.code == CMD_RD_ENA);

  // ==========================================================================
  // Error cause mapping
  always_comb begin
    err_set = '0;
    err_set[ERR_CMP5:ERR_CMP1] = err_i.cmp_stop; // [R1] [R2]
    err_set[ERR_PEL] = err_i.pos_end_limit_in; // [R3]
    err_set[ERR_NEL] = err_i.neg_end_limit_in; // [R3]
    err_set[ERR_ALM] = err_i.alarm_in; // [R3]
    err_set[ERR_SSTP] = err_i.sync_stop; // [R4]
    err_set[ERR_EMG] = err_i.emergency_stop; // [R4]
    err_set[ERR_SD] = err_i.slowdown_stop; // [R5]
    err_set[ERR_UNDEF] = 1'b0; // [R5]
    err_set[ERR_DATA] = err_i.op_data; // [R6]
    err_set[ERR_IPART] = err_i.interp_partner; // [R7]
    err_set[ERR_POVF] = err_i.pulser_overflow; // [R8]
    err_set[ERR_IOVR] = err_i.interp_overrange; // [R9]
    err_set[ERR_ENC] = err_i.encoder_input; // [R10]
    err_set[ERR_PUL] = err_i.pulser_input; // [R10]
  end

  // ==========================================================================
  // Event cause mapping
  always_comb begin
    evt_set = '0;
    evt_set[EV_ASTOP] = evt_i.auto_stop; // [R12]
    evt_set[EV_NEXT] = evt_i.next_start; // [R12]
    evt_set[EV_PREG] = evt_i.preg_writable; // [R13]
    evt_set[EV_C5PREG] = evt_i.cmp5_preg_writable; // [R13]
    evt_set[EV_ACC_S] = evt_i.accel_start; // [R14]
    evt_set[EV_ACC_E] = evt_i.accel_end; // [R14]
    evt_set[EV_DEC_S] = evt_i.decel_start; // [R14]
    evt_set[EV_DEC_E] = evt_i.decel_end; // [R14]
    evt_set[EV_CMP1 +: NUM_CMP] = evt_i.cmp_match; // [R14]
    evt_set[EV_CLR] = evt_i.counter_cleared; // [R15]
    evt_set[EV_LTC] = evt_i.counter_latched; // [R15]
    evt_set[EV_ORG] = evt_i.origin_latched; // [R15]
    evt_set[EV_SD] = evt_i.slowdown_on | rise[0]; // [R16]
    evt_set[EV_PDR] = change[1]; // [R17]
    evt_set[EV_NDR] = change[2]; // [R17]
    evt_set[EV_STA] = rise[3]; // [R18]
  end

  assign evt_gate = ena_to_cause(event_irq_enable_reg);

  // ==========================================================================
  // Sticky cause updates
  always_comb begin
    error_stop_cause_next = error_stop_cause_reg;
    if (rd_err) begin
      error_stop_cause_next = '0; // [R21]
    end
    error_stop_cause_next = error_stop_cause_next | err_set; // [R23]
    event_cause_next = event_cause_reg;
    if (rd_evt) begin
      event_cause_next = '0; // [R21]
    end
    event_cause_next = event_cause_next | evt_set; // [R11] [R23]
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      error_stop_cause_reg <= ERR_RST;
    end else begin
      error_stop_cause_reg <= error_stop_cause_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_cause_reg <= EVT_RST;
    end else begin
      event_cause_reg <= event_cause_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_irq_enable_reg <= ENA_RST;
    end else if (wr_ena) begin
      event_irq_enable_reg <= cmd_i.wdata[ENA_W-1:0];
    end
  end

  // ==========================================================================
  // Data buffer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_o <= '0;
      buf_valid_o <= 1'b0;
    end else begin
      buf_valid_o <= rd_err | rd_evt | rd_ena;
      if (rd_err) begin
        buf_o <= BUF_W'(error_stop_cause_reg); // [R21]
      end else if (rd_evt) begin
        buf_o <= BUF_W'(event_cause_reg); // [R21]
      end else if (rd_ena) begin
        buf_o <= BUF_W'(event_irq_enable_reg);
      end
    end
  end

  // ==========================================================================
  // Interrupt output
  assign irq_req = (|error_stop_cause_next) // [R19]
                   | (|(event_cause_next & evt_gate)); // [R11] [R20]

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_n_o <= 1'b1;
      err_pending_o <= 1'b0;
      evt_pending_o <= 1'b0;
    end else begin
      int_n_o <= !(irq_req && !int_mask_i); // [R22] [R20]
      err_pending_o <= |error_stop_cause_next;
      evt_pending_o <= |(event_cause_next & evt_gate);
    end
  end

endmodule
`default_nettype wire

// ===== dv/aicl_monitor.sv
// Port checker for the interrupt cause logic.
`timescale 1ns/100ps
`default_nettype none
module aicl_monitor
  import aicl_pkg::*;
(
  // Clock, reset and inputs
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire aicl_err_t err_i,
  input wire logic int_mask_i,
  input wire aicl_cmd_t cmd_i,
  // Outputs
  input wire logic [BUF_W-1:0] buf_o,
  input wire logic buf_valid_o,
  input wire logic err_pending_o,
  input wire logic evt_pending_o,
  input wire logic int_n_o
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_cmd;
  logic rd_err;
  assign rd_err = cmd_i.valid && cmd_i.code == CMD_RD_ERR;
  assign rd_cmd = rd_err || (cmd_i.valid && cmd_i.code inside {CMD_RD_EVT, CMD_RD_ENA});
  read_answer_a: assert property (rd_cmd |=> buf_valid_o) else $error("no answer");
  no_answer_a: assert property (!rd_cmd |=> !buf_valid_o) else $error("stray answer");
  buf_hold_a: assert property (!buf_valid_o |-> $stable(buf_o)) else $error("buf moved");
  err_latch_a: assert property (|err_i |=> err_pending_o) else $error("cause lost");
  err_int_a: assert property (|err_i && !int_mask_i |=> !int_n_o) else $error("no int");
  mask_high_a: assert property (int_mask_i |=> int_n_o) else $error("mask ignored");
  int_level_a: assert property (!$past(int_mask_i) |->
    int_n_o == !(err_pending_o || evt_pending_o)) else $error("int level wrong");
  read_clear_a: assert property (rd_err && !(|err_i) |=> !err_pending_o)
    else $error("not cleared");
  bit_undef_a: assert property (rd_err |=> !buf_o[ERR_UNDEF]) else $error("bit 11 set");
endmodule
bind aicl_top aicl_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .err_i(err_i),
  .int_mask_i(int_mask_i), .cmd_i(cmd_i), .buf_o(buf_o), .buf_valid_o(buf_valid_o),
  .err_pending_o(err_pending_o), .evt_pending_o(evt_pending_o), .int_n_o(int_n_o));
`default_nettype wire

// ===== dv/aicl_host_model.sv
// Host model that issues commands and collects the data buffer.
`timescale 1ns/100ps
`default_nettype none
module aicl_host_model
  import aicl_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Answer
  input wire logic [BUF_W-1:0] buf_i,
  input wire logic buf_valid_i,
  // Command
  output var aicl_cmd_t cmd_o
);
  initial cmd_o = '0;
  // One strobe per command; released fields are scrambled.
  task automatic send(input logic [CMD_W-1:0] code, input logic [BUF_W-1:0] wdata,
                      output logic [BUF_W-1:0] rdata, output logic vld);
    @(posedge clk_i);
    #1 cmd_o = '{valid: 1'b1, code: code, wdata: wdata};
    @(posedge clk_i);
    #1 cmd_o = '{valid: 1'b0, code: ~code, wdata: ~wdata};
    rdata = buf_i;
    vld = buf_valid_i;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench for the interrupt cause logic.
`timescale 1ns/100ps
`default_nettype none
module tb
  import aicl_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  aicl_err_t err_i = '0;
  aicl_evt_t evt_i = '0;
  logic sd_i = 1'b0, pdr_i = 1'b0, ndr_i = 1'b0, sta_i = 1'b0, mask_i = 1'b0;
  aicl_cmd_t cmd;
  logic [BUF_W-1:0] buf_o, rd;
  logic buf_valid_o, err_pending_o, evt_pending_o, int_n_o, vld;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  aicl_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .err_i(err_i), .evt_i(evt_i),
    .slow_down_in_i(sd_i), .pos_direction_in_i(pdr_i), .neg_direction_in_i(ndr_i),
    .ext_start_in_i(sta_i), .int_mask_i(mask_i), .cmd_i(cmd), .buf_o(buf_o),
    .buf_valid_o(buf_valid_o), .err_pending_o(err_pending_o),
    .evt_pending_o(evt_pending_o), .int_n_o(int_n_o));
  aicl_host_model u_host (.clk_i(clk_i), .buf_i(buf_o), .buf_valid_i(buf_valid_o),
    .cmd_o(cmd));
  // ==========================================================================
  // Helpers
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [BUF_W-1:0] got, input logic [BUF_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rdc(input logic [CMD_W-1:0] code, input logic [BUF_W-1:0] exp);
    u_host.send(code, '0, rd, vld);
    chk(rd, exp);
    chk(32'(vld), 32'h1);
  endtask
  function automatic int ef(int k);
    return k < 5 ? 12 + k : (k <= 10 ? 16 - k : 17 - k);
  endfunction
  function automatic int vf(int k);
    return (k >= 8 && k <= 12) ? k - 4 : 16 - k;
  endfunction
  // ==========================================================================
  // Scenarios
  task automatic s_reset();
    chk(32'({int_n_o, err_pending_o, evt_pending_o}), 32'h4);
    chk(buf_o, 32'h0);
    rdc(CMD_RD_ERR, 32'h0);
    rdc(CMD_RD_EVT, 32'h0);
    rdc(CMD_RD_ENA, 32'h0);
  endtask
  task automatic s_err();
    for (int k = 0; k < ERR_W; k++) begin
      if (k != ERR_UNDEF) begin
        err_i[ef(k)] = 1'b1;
        step(1);
        err_i = '0;
        chk(32'(int_n_o), 32'h0);
        rdc(CMD_RD_ERR, 32'h1 << k);
        chk(32'(int_n_o), 32'h1);
      end
    end
  endtask
  task automatic s_evt();
    u_host.send(CMD_WR_ENA, 32'h7FFFF, rd, vld);
    rdc(CMD_RD_ENA, 32'h7FFFF);
    for (int k = 0; k < 17; k++) begin
      evt_i[vf(k)] = 1'b1;
      step(1);
      evt_i = '0;
      chk(32'(int_n_o), 32'h0);
      rdc(CMD_RD_EVT, 32'h1 << k);
    end
    err_i.alarm_in = 1'b1;
    evt_i.auto_stop = 1'b1;
    step(1);
    err_i = '0;
    evt_i = '0;
    rdc(CMD_RD_ERR, 32'h80);
    chk(32'(int_n_o), 32'h0);
    rdc(CMD_RD_EVT, 32'h1);
    chk(32'(int_n_o), 32'h1);
  endtask
  task automatic s_gate();
    u_host.send(CMD_WR_ENA, 32'h20000, rd, vld);
    sta_i = 1'b1;
    step(3);
    chk(32'({int_n_o, evt_pending_o}), 32'h2);
    rdc(CMD_RD_EVT, 32'h80000);
    pdr_i = 1'b1;
    step(3);
    chk(32'(int_n_o), 32'h0);
    rdc(CMD_RD_EVT, 32'h20000);
    pdr_i = 1'b0;
    ndr_i = 1'b1;
    step(3);
    rdc(CMD_RD_EVT, 32'h60000);
    sd_i = 1'b1;
    step(3);
    chk(32'(int_n_o), 32'h1);
    rdc(CMD_RD_EVT, 32'h10000);
  endtask
  task automatic s_mask();
    mask_i = 1'b1;
    err_i.alarm_in = 1'b1;
    step(1);
    err_i = '0;
    step(1);
    chk(32'({int_n_o, err_pending_o}), 32'h3);
    mask_i = 1'b0;
    step(1);
    chk(32'(int_n_o), 32'h0);
    rdc(CMD_RD_ERR, 32'h80);
  endtask
  task automatic s_accum();
    err_i.cmp_stop[0] = 1'b1;
    step(1);
    err_i = '0;
    err_i.alarm_in = 1'b1;
    step(1);
    err_i = '0;
    err_i.op_data = 1'b1;
    rdc(CMD_RD_ERR, 32'h1081);
    err_i = '0;
    rdc(CMD_RD_ERR, 32'h1000);
    u_host.send(8'h00, '0, rd, vld);
    chk(32'(vld), 32'h0);
    rdc(CMD_RD_ERR, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    s_reset();
    s_err();
    s_evt();
    s_gate();
    s_mask();
    s_accum();
    wrap_up();
  end
endmodule
`default_nettype wire
